// ===== dv/spm_peer_model.sv
// spm_peer_model: spi peripheral on the far side of the port
// assumes the port masters the clock, clock_polarity 0 and clock_edge 1
`timescale 1ns/10ps
module spm_peer_model (
    input  wire logic        sck_i,
    input  wire logic        sdo_i,
    input  wire logic        load_i,
    input  wire logic        w16_i,
    input  wire logic [15:0] word_i,
    output logic             sdi_o,
    output logic      [15:0] got_o
);
    logic [15:0] tx_ff = 16'h5555;

    initial got_o = 16'h0000;
    // first bit stands before the first rising clock
    assign sdi_o = tx_ff[15];
    // shift on the falling clock; refill toggles so a stale bit never looks valid
    always @(posedge load_i or negedge sck_i) begin
        if (load_i)
            tx_ff <= w16_i ? word_i : {word_i[7:0], 8'h00};
        else
            tx_ff <= {tx_ff[14:0], ~tx_ff[0]};
    end
    // capture on the idle-to-active clock edge
    always @(posedge load_i or posedge sck_i) begin
        if (load_i)
            got_o <= 16'h0000;
        else
            got_o <= {got_o[14:0], sdo_i};
    end
endmodule

// ===== dv/spm_top_props.sv
// spm_top_props: bus and pin checks on the serial port top
// assumes it is bound onto spm_top and sees only its ports
`timescale 1ns/10ps
module spm_top_props (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o,
    input  wire logic        hresp_o,
    input  wire logic        sck_o,
    input  wire logic        sck_oe_o,
    input  wire logic        sdo_oe_o,
    input  wire logic        ss_oe_o
);
    default clocking @(posedge ref_clk_i);
    endclocking

    // a read taken at one address
    sequence rd_at(logic [31:0] a);
        hsel_i && htrans_i[1] && !hwrite_i && hready_i && (haddr_i == a);
    endsequence

    // spare bits of a read word must come back zero in the data phase
    property rd_zero(logic [31:0] a, logic [31:0] m);
        disable iff (rst_i) rd_at(a) |=> ((hrdata_o & m) == 32'h0);
    endproperty

    stat_spare_a: assert property (rd_zero(32'h0, 32'hffff_5fbc))
        else $error("status word shows a spare bit");
    con1_spare_a: assert property (rd_zero(32'h4, 32'hffff_e000))
        else $error("control one shows a spare bit");
    con2_spare_a: assert property (rd_zero(32'h8, 32'hffff_1ffd))
        else $error("control two shows a spare bit");
    unmapped_zero_a: assert property (rd_zero(32'h10, 32'hffff_ffff))
        else $error("unmapped read not zero");
    // zero wait states: ready from the first edge after release
    ready_up_a: assert property (disable iff (rst_i) 1'b1 |=> hreadyout_o)
        else $error("bus ready dropped");
    resp_okay_a: assert property (disable iff (rst_i) hresp_o == 1'b0)
        else $error("bus response not okay");
    // a reset disables the port, so every pin is let go
    pins_freed_a: assert property (rst_i |=> !sck_oe_o && !sdo_oe_o && !ss_oe_o)
        else $error("pin driven after reset");
    // both prescalers at one is illegal, so a clock level lasts two cycles at least
    sck_hold_a: assert property (disable iff (rst_i) $changed(sck_o) |=> $stable(sck_o))
        else $error("shift clock level lasted one cycle");
endmodule

bind spm_top spm_top_props i_props (.*);

// ===== dv/spm_top_tb.sv
// spm_top_tb: register and master-link regression for the serial port
// assumes spm_top, the peer model and the bound checker are compiled with it
`timescale 1ns/10ps
module spm_top_tb;
    logic        ref_clk;
    logic        rst = 1'b1;
    logic        idle = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic        ld = 1'b0;
    logic        w16 = 1'b0;
    logic [15:0] pword = 16'h0;
    logic [31:0] hrdata, rd;
    logic        hrdy, hresp, sck_o, sck_oe, sdo, sdo_oe, ss_o, ss_oe, sdi;
    logic [15:0] got;
    int          bad_count = 0;
    int          n_compared = 0;
    // released clock is pulled low; released data toggles so it never looks valid
    wire         sck_w = sck_oe & sck_o;
    wire         sdo_w = sdo_oe ? sdo : ref_clk;

    spm_top i_dut (
        .ref_clk_i(ref_clk), .rst_i(rst), .idle_i(idle), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .ss_i(1'b1), .ss_o(ss_o),
        .ss_oe_o(ss_oe)
    );
    spm_peer_model i_peer (
        .sck_i(sck_w), .sdo_i(sdo_w), .load_i(ld), .w16_i(w16), .word_i(pword),
        .sdi_o(sdi), .got_o(got)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one edge at a time until the slave is ready, bounded
    task automatic rdy_wait();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask

    // single word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        rdy_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy_wait();
        rd = hrdata;
    endtask

    // read status until bit b is set, bounded
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, 32'h0, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 200);
        if (rd[b] !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask

    // count reference cycles of one high level of the shift clock
    task automatic half_per(input int exp);
        int n;
        int p;
        n = 0;
        p = 0;
        while (sck_o !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        while (sck_o === 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
            p++;
        end
        check(32'(p), 32'(exp));
    endtask

    // arm the peer with its reply, then load the transmit word
    task automatic xfer(input logic [15:0] tx, input logic [15:0] rx, input logic wide);
        w16 <= wide;
        pword <= rx;
        ld <= 1'b1;
        @(posedge ref_clk);
        ld <= 1'b0;
        bus(1'b1, 32'hc, {16'h0, tx});
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 20; a += 4) begin
            bus(1'b0, 32'(a), 32'h0);
            check(rd, 32'h0);
        end
        $display("test reset values done");
        bus(1'b1, 32'h4, 32'hffff_ffff);
        bus(1'b0, 32'h4, 32'h0);
        check(rd, 32'h1fff);
        bus(1'b1, 32'h8, 32'hffff_ffff);
        bus(1'b0, 32'h8, 32'h0);
        check(rd, 32'he002);
        bus(1'b1, 32'h8, 32'h0);
        bus(1'b1, 32'h4, 32'h0);
        bus(1'b1, 32'h0, 32'hffff_ffff);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'ha000);
        bus(1'b1, 32'h0, 32'h0);
        $display("test register masks done");
        bus(1'b1, 32'h4, 32'h13e);
        bus(1'b1, 32'h0, 32'h8000);
        xfer(16'h00a5, 16'h003c, 1'b0);
        half_per(4);
        poll(0);
        check({30'h0, sck_oe, sdo_oe}, 32'h3);
        check({16'h0, got}, 32'h00a5);
        bus(1'b0, 32'hc, 32'h0);
        check(rd, 32'h3c);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h8000);
        $display("test byte transfer done");
        xfer(16'h0011, 16'h0081, 1'b0);
        poll(0);
        xfer(16'h0022, 16'h0042, 1'b0);
        poll(6);
        check(rd, 32'h8041);
        bus(1'b0, 32'hc, 32'h0);
        check(rd, 32'h81);
        bus(1'b1, 32'h0, 32'h8000);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h8000);
        $display("test overflow done");
        bus(1'b1, 32'h4, 32'h53e);
        xfer(16'h1234, 16'hbeef, 1'b1);
        half_per(4);
        poll(0);
        check({16'h0, got}, 32'h1234);
        bus(1'b0, 32'hc, 32'h0);
        check(rd, 32'hbeef);
        $display("test word transfer done");
        bus(1'b1, 32'h0, 32'ha000);
        idle <= 1'b1;
        xfer(16'h0f0f, 16'h5a5a, 1'b1);
        repeat (100) @(posedge ref_clk);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'ha002);
        idle <= 1'b0;
        poll(0);
        check(rd, 32'ha001);
        check({16'h0, got}, 32'h0f0f);
        bus(1'b0, 32'hc, 32'h0);
        check(rd, 32'h5a5a);
        $display("test stop in idle done");
        bus(1'b1, 32'h4, 32'h1d3e);
        bus(1'b0, 32'h4, 32'h0);
        check({30'h0, sck_oe, sdo_oe}, 32'h0);
        bus(1'b1, 32'h4, 32'h13e);
        bus(1'b1, 32'h0, 32'h0);
        bus(1'b0, 32'h0, 32'h0);
        check({28'h0, ss_o, sck_oe, sdo_oe, ss_oe}, 32'h8);
        $display("test pin release done");
        end_sim();
    end
endmodule

// ===== rtl/spm_defines.svh
// spm_defines.svh: register offsets, write masks, word lengths and prescale constants
// for the framed serial port; included by the package users, definitions only.
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// register byte offsets inside the 16-byte window
`define SPM_ADDR_STAT     4'h0
`define SPM_ADDR_CON1     4'h4
`define SPM_ADDR_CON2     4'h8
`define SPM_ADDR_BUF      4'hc

// writable bits of each control word; the rest read as zero
`define SPM_CON1_WMASK    16'h1fff
`define SPM_CON2_WMASK    16'he002

// ahb transfer type bit that marks NONSEQ/SEQ
`define SPM_HTRANS_ACT    1

// word lengths in bits
`define SPM_LEN_BYTE      5'd8
`define SPM_LEN_WORD      5'd16

// master prescalers: secondary divides by base minus code, primary by 4 per step
`define SPM_SEC_BASE      4'h8
`define SPM_PRI_TOP       2'h3
`define SPM_PRI_ONE       7'h01

// pin inputs passed through the synchroniser: sck, sdi, ss
`define SPM_PIN_W         3

`endif

// ===== rtl/spm_pkg.sv
// spm_pkg: types of the serial port top; its synchroniser declares its own.
// assumes spm_defines.svh is compiled with it.
package spm_pkg;

    // control word one, field order as held in the register
    typedef struct packed {
        logic [2:0] unused;
        logic       clock_pin_disable;
        logic       data_out_disable;
        logic       word_width_select;
        logic       sample_phase;
        logic       clock_edge;
        logic       slave_select_enable;
        logic       clock_polarity;
        logic       master_select;
        logic [2:0] secondary_prescale;
        logic [1:0] primary_prescale;
    } spm_con1_t;

    // control word two
    typedef struct packed {
        logic        framed_mode_enable;
        logic        sync_direction;
        logic        sync_polarity;
        logic [10:0] unused_hi;
        logic        sync_edge_select;
        logic        unused_lo;
    } spm_con2_t;

    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_SYNC,
        SPM_SHIFT
    } spm_mst_t;

    // all state of the top module
    typedef struct packed {
        logic        port_enable;
        logic        stop_in_idle;
        logic        receive_overflow_flag;
        logic        transmit_full_flag;
        logic        receive_full_flag;
        spm_con1_t   con1;
        spm_con2_t   con2;
        logic [15:0] transmit_buffer;
        logic [15:0] receive_buffer;
        logic [15:0] shift_register;
        logic        rx_bit;
        logic        samp;
        logic        armed;
        logic [4:0]  bitcnt;
        logic [4:0]  ecnt;
        logic [9:0]  pre_cnt;
        spm_mst_t    mst;
        logic        sck_lvl;
        logic        sck_prev;
        logic        a_valid;
        logic        a_write;
        logic        a_hit;
        logic [3:0]  a_addr;
        logic [31:0] hrdata;
        logic        hready;
        logic        sck_o;
        logic        sck_oe;
        logic        sdo_o;
        logic        sdo_oe;
        logic        ss_o;
        logic        ss_oe;
    } spm_state_t;

endpackage

// ===== rtl/spm_sync.sv
// spm_sync: two-flop synchroniser for pin levels entering the ref_clk_i domain.
// assumes the inputs are asynchronous levels; only the second flop is visible.
`timescale 1ns/10ps
module spm_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } spm_sync_st_t;

    spm_sync_st_t st_ff;
    spm_sync_st_t nxt_st;

    // first stage feeds only the second stage
    always_comb begin
        nxt_st.meta = d_i;
        nxt_st.hold = st_ff.meta;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.hold;
endmodule

// ===== rtl/spm_top.sv
// spm_top: framed serial port, master or slave, 8/16-bit words, with ahb-lite registers.
// assumes one ahb-lite master on ref_clk_i and pins that are asynchronous to it.
// idle_i is already on ref_clk_i and skips the synchroniser.
// slave edges lag the pin by two to three cycles; keep its clock slow.
// Notes on behaviour
// [RQ1] one 16-bit shift register, apart from the software buffer location
// [RQ2] master select high drives the shift clock; low takes it from outside
// [RQ3] port enable claims the four serial pins; low disables the port
// [RQ4] stop-in-idle high freezes the port while the device idles
// [RQ5] word finishing on an unread buffer is dropped and overflow flag set
// [RQ6] transmit full sets on buffer write, clears when shift register loads
// [RQ7] receive full sets when a word lands, clears on buffer read
// [RQ8] master clock disable stops shifting and frees the pin; data-out disable frees data
// [RQ9] word width bit: one gives 16-bit, zero gives 8-bit transfers
// [RQ10] master samples at end of output time when set, middle when clear
// [RQ11] software keeps sample phase zero in slave mode
// [RQ12] clock edge one: data changes active-to-idle; zero: idle-to-active
// [RQ13] clock edge is ignored in framed mode and programmed zero there
// [RQ14] slave select enable makes the slave honour the active-low select pin
// [RQ15] clock polarity one idles high, zero idles low
// [RQ16] secondary prescale code 111 divides by 1, down to 000 by 8
// [RQ17] primary prescale 11 by 1, 10 by 4, 01 by 16, 00 by 64
// [RQ18] software never sets both prescalers to one
// [RQ19] framed mode turns the select pin into a frame sync pulse
// [RQ20] sync direction one takes sync from outside, zero drives it
// [RQ21] sync polarity one means active-high pulse, zero active-low
// [RQ22] sync edge one coincides with first bit clock, zero precedes it
`timescale 1ns/10ps
`include "spm_defines.svh"
module spm_top (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        idle_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    input  wire logic        ss_i,
    output logic             ss_o,
    output logic             ss_oe_o
);
    import spm_pkg::*;

    spm_state_t st_ff;
    spm_state_t nxt_st;
    logic [`SPM_PIN_W-1:0] pin_s;
    logic sck_s;
    logic sdi_s;
    logic ss_s;

    // pins are asynchronous, so nothing reads them before two flops
    spm_sync #(.W(`SPM_PIN_W)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .d_i       ({sck_i, sdi_i, ss_i}),
        .q_o       (pin_s)
    );
    assign {sck_s, sdi_s, ss_s} = pin_s;

    // mode, select and sync helpers
    logic        run;
    logic        master;
    logic        framed;
    logic        cke_eff;
    logic        smp_eff;
    logic        sync_act;
    logic        sync_drv;
    logic        selected;

    // per-cycle strobes
    logic        tick;
    logic        edge_ev;
    logic        lead;
    logic        do_shift;
    logic        sbit;
    logic        fin;
    logic        buf_wr;

    // word length, divider and next shift word
    logic [4:0]  wlen;
    logic [6:0]  pri_div;
    logic [3:0]  sec_div;
    logic [10:0] div_full;
    logic [9:0]  div_m1;
    logic [15:0] sr_n;

    // clock divide from the two prescalers
    always_comb begin
        pri_div  = `SPM_PRI_ONE << {(`SPM_PRI_TOP - st_ff.con1.primary_prescale), 1'b0}; // RQ17
        sec_div  = `SPM_SEC_BASE - {1'b0, st_ff.con1.secondary_prescale}; // RQ16
        div_full = pri_div * sec_div;
        div_m1   = div_full[9:0] - 10'h001;
    end

    always_comb begin
        nxt_st   = st_ff;

        run      = st_ff.port_enable & ~(st_ff.stop_in_idle & idle_i); // RQ4
        master   = st_ff.con1.master_select; // RQ2
        framed   = st_ff.con2.framed_mode_enable;
        cke_eff  = st_ff.con1.clock_edge & ~framed; // RQ13
        smp_eff  = st_ff.con1.sample_phase & master; // RQ10 RQ11
        wlen     = st_ff.con1.word_width_select ? `SPM_LEN_WORD : `SPM_LEN_BYTE; // RQ9
        sync_act = (ss_s == st_ff.con2.sync_polarity); // RQ21
        selected = ~st_ff.con1.slave_select_enable | ~ss_s; // RQ14

        sync_drv = 1'b0;
        tick     = 1'b0;
        edge_ev  = 1'b0;
        lead     = 1'b0;
        do_shift = 1'b0;
        sbit     = 1'b0;
        fin      = 1'b0;
        sr_n     = st_ff.shift_register;
        buf_wr   = st_ff.a_valid & st_ff.a_write & st_ff.a_hit & (st_ff.a_addr == `SPM_ADDR_BUF);

        // ahb address phase: zero wait states, reads answered from the next flop
        nxt_st.hready  = 1'b1;
        nxt_st.a_valid = hsel_i & htrans_i[`SPM_HTRANS_ACT] & hready_i;
        nxt_st.a_write = hwrite_i;
        nxt_st.a_hit   = (haddr_i[31:4] == 28'h0000000);
        nxt_st.a_addr  = haddr_i[3:0];

        if (nxt_st.a_valid & ~hwrite_i) begin
            nxt_st.hrdata = 32'h00000000;
            if (nxt_st.a_hit) begin
                case (haddr_i[3:0])
                    `SPM_ADDR_STAT: nxt_st.hrdata[15:0] = {st_ff.port_enable, 1'b0,
                        st_ff.stop_in_idle, 6'h00, st_ff.receive_overflow_flag,
                        4'h0, st_ff.transmit_full_flag, st_ff.receive_full_flag};
                    `SPM_ADDR_CON1: nxt_st.hrdata[15:0] = st_ff.con1 & `SPM_CON1_WMASK;
                    `SPM_ADDR_CON2: nxt_st.hrdata[15:0] = st_ff.con2 & `SPM_CON2_WMASK;
                    `SPM_ADDR_BUF: begin
                        nxt_st.hrdata[15:0]      = st_ff.receive_buffer;
                        nxt_st.receive_full_flag = 1'b0; // RQ7
                    end
                    default: nxt_st.hrdata = 32'h00000000;
                endcase
            end
        end

        // ahb data phase writes; unmapped addresses are ignored
        if (st_ff.a_valid & st_ff.a_write & st_ff.a_hit) begin
            case (st_ff.a_addr)
                `SPM_ADDR_STAT: begin
                    nxt_st.port_enable  = hwdata_i[15];
                    nxt_st.stop_in_idle = hwdata_i[13];
                    // overflow is clear-only: writing zero clears it
                    if (!hwdata_i[6]) begin
                        nxt_st.receive_overflow_flag = 1'b0; // RQ5
                    end
                end
                `SPM_ADDR_CON1: nxt_st.con1 = hwdata_i[15:0] & `SPM_CON1_WMASK;
                `SPM_ADDR_CON2: nxt_st.con2 = hwdata_i[15:0] & `SPM_CON2_WMASK;
                `SPM_ADDR_BUF: begin
                    nxt_st.transmit_buffer    = hwdata_i[15:0];
                    nxt_st.transmit_full_flag = 1'b1; // RQ6
                end
                default: nxt_st.port_enable = st_ff.port_enable;
            endcase
        end

        // disabled port: engine back to rest, flags and buffers kept
        if (!st_ff.port_enable) begin
            nxt_st.mst      = SPM_IDLE;
            nxt_st.bitcnt   = 5'h00;
            nxt_st.ecnt     = 5'h00;
            nxt_st.samp     = 1'b0;
            nxt_st.armed    = 1'b0;
            nxt_st.pre_cnt  = 10'h000;
            nxt_st.sck_lvl  = st_ff.con1.clock_polarity; // RQ15
            nxt_st.sck_prev = sck_s;
        end else if (run && master) begin
            // master: a tick is one half bit clock, clock disable stalls it
            if (st_ff.mst != SPM_IDLE && !st_ff.con1.clock_pin_disable) begin // RQ8
                tick = (st_ff.pre_cnt == div_m1);
                nxt_st.pre_cnt = tick ? 10'h000 : st_ff.pre_cnt + 10'h001;
            end

            case (st_ff.mst)
                SPM_IDLE: begin
                    nxt_st.sck_lvl = st_ff.con1.clock_polarity; // RQ15
                    // external sync must be seen before a framed word starts
                    if (st_ff.transmit_full_flag &&
                        (!framed || !st_ff.con2.sync_direction || sync_act)) begin // RQ20
                        nxt_st.shift_register     = st_ff.transmit_buffer; // RQ1
                        nxt_st.transmit_full_flag = buf_wr; // RQ6
                        nxt_st.ecnt    = 5'h00;
                        nxt_st.pre_cnt = 10'h000;
                        nxt_st.mst     = (framed && !st_ff.con2.sync_edge_select) ?
                                         SPM_SYNC : SPM_SHIFT; // RQ22
                    end
                end

                SPM_SYNC: begin
                    // one whole bit clock of sync ahead of the first data bit
                    sync_drv = 1'b1; // RQ22
                    if (tick) begin
                        nxt_st.sck_lvl = ~st_ff.sck_lvl;
                        nxt_st.ecnt    = st_ff.ecnt + 5'h01;
                        if (st_ff.ecnt[0]) begin
                            nxt_st.ecnt = 5'h00;
                            nxt_st.mst  = SPM_SHIFT;
                        end
                    end
                end

                SPM_SHIFT: begin
                    sync_drv = st_ff.con2.sync_edge_select && (st_ff.ecnt < 5'h02); // RQ22
                    if (tick) begin
                        edge_ev        = 1'b1;
                        lead           = (st_ff.sck_lvl == st_ff.con1.clock_polarity);
                        nxt_st.sck_lvl = ~st_ff.sck_lvl; // RQ2
                        nxt_st.ecnt    = st_ff.ecnt + 5'h01;
                    end
                end
                default: nxt_st.mst = SPM_IDLE;
            endcase
        end else if (run) begin
            // slave: edges of the synchronised outside clock
            nxt_st.sck_prev = sck_s;
            lead = (st_ff.sck_prev == st_ff.con1.clock_polarity);

            if (framed) begin
                if (!st_ff.armed && st_ff.con2.sync_direction) begin
                    // sync seen on a leading edge arms the word
                    if (sck_s != st_ff.sck_prev && lead && sync_act) begin // RQ20
                        nxt_st.armed = 1'b1;
                        edge_ev      = st_ff.con2.sync_edge_select; // RQ22
                    end
                end else if (!st_ff.armed && st_ff.transmit_full_flag) begin
                    nxt_st.armed = 1'b1;
                end else if (st_ff.armed) begin
                    edge_ev = (sck_s != st_ff.sck_prev);
                end
                sync_drv = st_ff.armed && !st_ff.con2.sync_direction &&
                           (st_ff.bitcnt == 5'h00) && !st_ff.samp; // RQ19
            end else if (!selected) begin
                // deselected slave drops a partial word
                nxt_st.bitcnt = 5'h00;
                nxt_st.samp   = 1'b0;
            end else begin
                edge_ev = (sck_s != st_ff.sck_prev);
            end

            // a fresh word loads only between words
            if (st_ff.transmit_full_flag && st_ff.bitcnt == 5'h00 && !st_ff.samp &&
                (!framed || !st_ff.armed)) begin
                nxt_st.shift_register     = st_ff.transmit_buffer; // RQ1
                nxt_st.transmit_full_flag = buf_wr; // RQ6
                sr_n = st_ff.transmit_buffer;
            end
        end

        // common bit engine: mid edge samples, change edge shifts
        if (edge_ev) begin
            if (lead == cke_eff) begin // RQ12
                // with data changing on the leading edge the last bit has no later change
                if (!cke_eff && st_ff.bitcnt == wlen - 5'h01) begin
                    do_shift = 1'b1;
                    sbit     = sdi_s;
                end else begin
                    nxt_st.rx_bit = sdi_s; // RQ10
                    nxt_st.samp   = 1'b1;
                end
            end else if (st_ff.samp) begin
                do_shift    = 1'b1;
                sbit        = smp_eff ? sdi_s : st_ff.rx_bit; // RQ10
                nxt_st.samp = 1'b0;
            end
        end

        if (do_shift) begin
            sr_n = {nxt_st.shift_register[14:0], sbit}; // RQ1
            nxt_st.shift_register = sr_n;
            nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
            fin = (st_ff.bitcnt + 5'h01 == wlen); // RQ9
        end

        // word complete: land it or flag the overflow
        if (fin) begin
            nxt_st.bitcnt = 5'h00;
            nxt_st.samp   = 1'b0;
            nxt_st.armed  = 1'b0;

            if (master) begin
                nxt_st.mst = SPM_IDLE;
            end
            // unread word blocks the new one; a same-cycle read frees the buffer first
            if (nxt_st.receive_full_flag) begin
                nxt_st.receive_overflow_flag = 1'b1; // RQ5
            end else begin
                nxt_st.receive_buffer    = st_ff.con1.word_width_select ? sr_n :
                                           {8'h00, sr_n[7:0]}; // RQ7
                nxt_st.receive_full_flag = 1'b1; // RQ7
            end
        end

        // pin drivers registered; clock and data levels from the next state, enables and sync from the current state
        nxt_st.sck_o  = nxt_st.sck_lvl;
        nxt_st.sck_oe = st_ff.port_enable & master & ~st_ff.con1.clock_pin_disable; // RQ3 RQ8
        nxt_st.sdo_o  = st_ff.con1.word_width_select ? nxt_st.shift_register[15] :
                        nxt_st.shift_register[7];
        nxt_st.sdo_oe = st_ff.port_enable & ~st_ff.con1.data_out_disable &
                        (master | framed | selected); // RQ3 RQ8
        nxt_st.ss_o   = sync_drv ? st_ff.con2.sync_polarity : ~st_ff.con2.sync_polarity; // RQ21
        nxt_st.ss_oe  = st_ff.port_enable & framed & ~st_ff.con2.sync_direction; // RQ19 RQ20
    end

    // synchronous reset: port disabled, all flags and registers zero
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // read data and ready straight from the state flops; response tied to okay
    assign hrdata_o    = st_ff.hrdata;
    assign hreadyout_o = st_ff.hready;
    assign hresp_o     = 1'b0;

    // serial pins
    assign sck_o       = st_ff.sck_o;
    assign sck_oe_o    = st_ff.sck_oe;
    assign sdo_o       = st_ff.sdo_o;
    assign sdo_oe_o    = st_ff.sdo_oe;
    assign ss_o        = st_ff.ss_o;
    assign ss_oe_o     = st_ff.ss_oe;
endmodule
